// ==== core/srr_link_rx.sv ====
// Module: serial link receiver on the bit clock, slot word capture
`timescale 1ns/1ps
`default_nettype none
module srr_link_rx #(
  parameter int WORD_W = 32
) (
  // Link clock and reset
  input wire logic bit_clock,
  input wire logic link_reset,
  // Frame pins
  input wire logic frame_sync,
  input wire logic serial_data,
  // Format, quasi-static
  input wire logic [5:0] word_len_m1,
  input wire logic two_half,
  // Captured words
  srr_slot_if.link slot_out
);
  // Elaboration check: shift path is built for 32-bit slots
  if (WORD_W != 32) begin : g_width_check
    $error("srr_link_rx supports WORD_W 32 only");
  end
  typedef struct packed {
    logic fs_d;
    logic [5:0] bit_cnt;
    logic [4:0] slot_cnt;
    logic [31:0] shift;
    logic [31:0] word;
    logic [4:0] slot;
    logic toggle;
  } srr_link_state_type;
  srr_link_state_type state, next_state;
  always_comb begin
    next_state = state;
    next_state.fs_d = frame_sync;
    next_state.shift = {state.shift[30:0], serial_data};
    if (frame_sync && !state.fs_d) begin
      next_state.bit_cnt = 6'h01;
      next_state.slot_cnt = 5'h00;
      next_state.shift = {31'h0, serial_data};
    end else if (state.bit_cnt == word_len_m1) begin
      // Word complete: hand off with slot number
      next_state.word = {state.shift[30:0], serial_data};
      next_state.slot = state.slot_cnt;
      next_state.toggle = ~state.toggle;
      // Clear so short words carry no bits of the last one
      next_state.shift = 32'h0;
      next_state.bit_cnt = 6'h00;
      next_state.slot_cnt = state.slot_cnt + 5'h01;
    end else begin
      next_state.bit_cnt = state.bit_cnt + 6'h01;
    end
    // Left/right framing: second half numbers from sixteen
    if (two_half && !frame_sync && state.fs_d) begin
      next_state.slot_cnt = 5'h10;
      next_state.bit_cnt = 6'h01;
      next_state.shift = {31'h0, serial_data};
    end
  end
  always_ff @(posedge bit_clock) begin
    if (link_reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign slot_out.word = state.word;
  assign slot_out.slot = state.slot;
  assign slot_out.toggle = state.toggle;
endmodule
`default_nettype wire

// ==== core/srr_pkg.sv ====
// Package: register map, field layout and constants of the receive router
// Summary of operation
// - Channel six source: off, playback, loopback, companion
// - Channel seven source: off, playback, loopback, companion
// - Channel eight source: off, playback, loopback, companion
// - Slot 0-15: TDM slot or left slot
// - Slot 16-31: TDM slot or right slot
// - Reset slots five, six, seven respectively
// - Reset sources of six, seven read zero
// - Bit seven reserved, reads zero, write zero
package srr_pkg;
  localparam logic [7:0] REG_CH6 = 8'h2D;
  localparam logic [7:0] REG_CH7 = 8'h2E;
  localparam logic [7:0] REG_CH8 = 8'h2F;
  localparam logic [7:0] REG_FMT = 8'h30;
  localparam int SRC_LSB = 5;
  localparam int SLOT_LSB = 0;
  localparam logic [7:0] RST_CH6 = 8'h05;
  localparam logic [7:0] RST_CH7 = 8'h06;
  localparam logic [7:0] RST_CH8 = 8'h07;
  localparam logic [7:0] RST_FMT = 8'h00;
  localparam logic [7:0] RSVD_MASK = 8'h7F;
  localparam int NUM_CH = 3;
  localparam int SLOT_W = 5;
  localparam int WORD_W = 32;
  localparam int HALF_SLOTS = 16;
  typedef enum logic [1:0] {
    SRC_OFF = 2'h0,
    SRC_PLAY = 2'h1,
    SRC_LOOP = 2'h2,
    SRC_LINK = 2'h3
  } srr_src_type;
endpackage

// ==== core/srr_router.sv ====
// Module: receive channel six to eight slot router with register port
`timescale 1ns/1ps
`default_nettype none
module srr_router (
  // System clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Link pins
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic serial_data,
  // Alternate sources, system clock domain
  input wire logic [95:0] loop_data,
  input wire logic [95:0] link_dev_data,
  // Routed outputs
  output logic [95:0] ch_data,
  output logic [2:0] ch_valid
);
  typedef struct packed {
    logic [2:0][7:0] cfg;
    logic [7:0] fmt;
    logic [7:0] rdata;
    logic [2:0] rst_l;
    logic [2:0] tog_s;
    logic tog_d;
    logic [2:0][31:0] data;
    logic [2:0] valid;
  } srr_state_type;
  srr_state_type state, next_state;
  srr_slot_if slot_bus();
  logic [1:0] lrst_sync;
  logic [4:0] fs1, fs2;
  logic [5:0] wl_m1;
  // Link reset and format, resynchronised to bit clock
  always_ff @(posedge bit_clock) begin
    lrst_sync <= {lrst_sync[0], reset};
    fs1 <= {2'h0, state.fmt[2:0]};
    fs2 <= fs1;
  end
  assign wl_m1 = (fs2[1:0] == 2'h0) ? 6'h0F : (fs2[1:0] == 2'h1) ? 6'h13 :
    (fs2[1:0] == 2'h2) ? 6'h17 : 6'h1F;
  srr_link_rx #(.WORD_W(32)) u_link (
    .bit_clock(bit_clock),
    .link_reset(lrst_sync[1]),
    .frame_sync(frame_sync),
    .serial_data(serial_data),
    .word_len_m1(wl_m1),
    .two_half(fs2[2]),
    .slot_out(slot_bus.link)
  );
  logic word_evt;
  logic [4:0] want;
  assign word_evt = state.tog_s[2] ^ state.tog_d;
  always_comb begin
    next_state = state;
    want = 5'h00;
    next_state.tog_s = {state.tog_s[1:0], slot_bus.toggle};
    next_state.tog_d = state.tog_s[2];
    next_state.valid = 3'h0;
    next_state.rdata = 8'h00;
    if (reg_write) begin
      case (reg_addr)
        srr_pkg::REG_CH6: next_state.cfg[0] = reg_wdata & srr_pkg::RSVD_MASK;
        srr_pkg::REG_CH7: next_state.cfg[1] = reg_wdata & srr_pkg::RSVD_MASK;
        srr_pkg::REG_CH8: next_state.cfg[2] = reg_wdata & srr_pkg::RSVD_MASK;
        srr_pkg::REG_FMT: next_state.fmt = {5'h00, reg_wdata[2:0]};
        default: next_state.fmt = state.fmt;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        srr_pkg::REG_CH6: next_state.rdata = state.cfg[0];
        srr_pkg::REG_CH7: next_state.rdata = state.cfg[1];
        srr_pkg::REG_CH8: next_state.rdata = state.cfg[2];
        srr_pkg::REG_FMT: next_state.rdata = state.fmt;
        default: next_state.rdata = 8'h00;
      endcase
    end
    for (int i = 0; i < 3; i++) begin
      // Slot index is TDM slot, or left 0-15 / right 16-31
      want = state.cfg[i][4:0];
      if (word_evt && slot_bus.slot == want) begin
        next_state.valid[i] = 1'b1;
        case (srr_pkg::srr_src_type'(state.cfg[i][6:5]))
          srr_pkg::SRC_OFF: next_state.data[i] = 32'h0;
          srr_pkg::SRC_PLAY: next_state.data[i] = slot_bus.word;
          srr_pkg::SRC_LOOP: next_state.data[i] = loop_data[i*32 +: 32];
          srr_pkg::SRC_LINK: next_state.data[i] = link_dev_data[i*32 +: 32];
          default: next_state.data[i] = 32'h0;
        endcase
      end
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= '0;
      state.cfg[0] <= srr_pkg::RST_CH6;
      state.cfg[1] <= srr_pkg::RST_CH7;
      state.cfg[2] <= srr_pkg::RST_CH8;
      state.fmt <= srr_pkg::RST_FMT;
    end else begin
      state <= next_state;
    end
  end
  assign reg_rdata = state.rdata;
  assign ch_data = {state.data[2], state.data[1], state.data[0]};
  assign ch_valid = state.valid;
  AST_RSVD_ZERO: assert property (@(posedge clock) disable iff (reset)
    reg_read |=> reg_rdata[7] == 1'b0) else $error("reserved bit set");
  AST_OFF_ZERO: assert property (@(posedge clock) disable iff (reset)
    ch_valid[0] && $past(state.cfg[0][6:5]) == 2'h0 |-> ch_data[31:0] == 32'h0)
    else $error("disabled channel data nonzero");
  AST_RESET_CFG: assert property (@(posedge clock)
    $past(reset) |-> state.cfg[0] == 8'h05 && state.cfg[1] == 8'h06 &&
    state.cfg[2] == 8'h07)
    else $error("reset value wrong");
  AST_WRITE_TAKE: assert property (@(posedge clock) disable iff (reset)
    reg_write && reg_addr == 8'h2D |=>
    state.cfg[0] == ($past(reg_wdata) & 8'h7F))
    else $error("write not taken");
  AST_PLAY_ROUTE: assert property (@(posedge clock) disable iff (reset)
    ch_valid[1] && $past(state.cfg[1][6:5]) == 2'h1 |->
    ch_data[63:32] == $past(slot_bus.word))
    else $error("playback word not routed");
  AST_LOOP_ROUTE: assert property (@(posedge clock) disable iff (reset)
    ch_valid[2] && $past(state.cfg[2][6:5]) == 2'h2 |->
    ch_data[95:64] == $past(loop_data[95:64]))
    else $error("loopback word not routed");
  AST_SLOT_MATCH: assert property (@(posedge clock) disable iff (reset)
    ch_valid[0] |-> $past(slot_bus.slot) == $past(state.cfg[0][4:0]))
    else $error("word taken from wrong slot");
endmodule
`default_nettype wire

// ==== core/srr_slot_if.sv ====
// Interface: slot word and slot number handoff from link to router, shared by all channels
`timescale 1ns/1ps
`default_nettype none
interface srr_slot_if;
  logic [31:0] word;
  logic [4:0] slot;
  logic toggle;
  modport link (output word, output slot, output toggle);
  modport core (input word, input slot, input toggle);
endinterface
`default_nettype wire

// ==== tb/srr_host_model.sv ====
// Host side frame driver for the receive slot router
`timescale 1ns/1ps
`default_nettype none
module srr_host_model (
  // Link pins
  output logic bit_clock,
  output logic frame_sync,
  output logic serial_data
);
  logic [31:0] word_tbl [32];
  initial begin
    bit_clock = 1'b0;
    frame_sync = 1'b0;
    serial_data = 1'b0;
  end
  // Idle clocks, data toggles so no stale bit is seen
  task automatic pulse(input int n);
    repeat (n) begin
      #24 bit_clock = 1'b1;
      #24 bit_clock = 1'b0;
      serial_data = ~serial_data;
    end
  endtask
  // Sync high over left half, low over right half, MSB first
  task automatic send_frame(input int bits);
    for (int k = 0; k < 32; k++) begin
      for (int b = bits - 1; b >= 0; b--) begin
        frame_sync = (k < 16);
        serial_data = word_tbl[k][b];
        #24 bit_clock = 1'b1;
        #24 bit_clock = 1'b0;
      end
    end
    frame_sync = 1'b0;
    pulse(2);
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking testbench of the receive slot router
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, reset, reg_write, reg_read, rd_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wire logic bit_clock, frame_sync, serial_data;
  logic [95:0] loop_data, link_dev_data, ch_data;
  logic [2:0] ch_valid;
  logic [1:0] src, wl;
  int bits;
  logic [4:0] slot [3];
  logic [31:0] exp_w;
  logic [33:0] exp_q [$];
  logic [7:0] rd_exp [$];
  int error_cnt, tests_run;
  srr_router i_srr_router (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .bit_clock(bit_clock),
    .frame_sync(frame_sync), .serial_data(serial_data),
    .loop_data(loop_data), .link_dev_data(link_dev_data),
    .ch_data(ch_data), .ch_valid(ch_valid));
  srr_host_model i_srr_host_model (.bit_clock(bit_clock),
    .frame_sync(frame_sync), .serial_data(serial_data));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input string what, input logic [33:0] e, g);
    tests_run++;
    if (e !== g) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, e);
    rd_exp.push_back(e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
  endtask
  // Scoreboard: oldest note against each result
  always @(posedge clock) begin
    rd_q <= reg_read;
    if (rd_q)
      check("reg_rdata", rd_exp.pop_front(), reg_rdata);
    for (int i = 0; i < 3; i++) begin
      if (ch_valid[i])
        check("ch_data", exp_q.pop_front(), {i[1:0], ch_data[i*32+:32]});
    end
  end
  initial begin
    #400000;
    error_cnt++;
    test_done();
  end
  initial begin
    {reg_write, reg_read, rd_q, reg_addr, reg_wdata} = '0;
    reset = 1'b1;
    void'($urandom(32'hC403));
    loop_data = '0;
    link_dev_data = '0;
    i_srr_host_model.pulse(3);
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    // Bit clock edges clear the link side reset
    i_srr_host_model.pulse(3);
    @(posedge clock);
    rd(8'h2D, 8'h05);
    rd(8'h2E, 8'h06);
    rd(8'h2F, 8'h07);
    wr(8'h2D, 8'h7F);
    rd(8'h2D, 8'h7F);
    wr(8'h41, 8'h55);
    rd(8'h41, 8'h00);
    for (int s = 0; s < 5; s++) begin
      src = (s == 4) ? 2'h1 : 2'(s);
      loop_data <= {$urandom, $urandom, $urandom};
      link_dev_data <= {$urandom, $urandom, $urandom};
      wl = 2'(s % 4);
      bits = (wl == 2'h3) ? 32 : 16 + 4 * wl;
      wr(8'h30, {5'h00, 1'(s), wl});
      for (int c = 0; c < 3; c++) begin
        slot[c] = 5'(c * 15 + s * 8 + (s == 3));
        wr(8'(8'h2D + c), {1'b0, src, slot[c]});
      end
      for (int k = 0; k < 32; k++) begin
        i_srr_host_model.word_tbl[k] = $urandom >> (32 - bits);
        for (int c = 0; c < 3; c++) begin
          exp_w = src == 2'h0 ? 32'h0 : src == 2'h1 ?
            i_srr_host_model.word_tbl[k] : src == 2'h2 ?
            loop_data[c*32+:32] : link_dev_data[c*32+:32];
          if (slot[c] == 5'(k))
            exp_q.push_back({2'(c), exp_w});
        end
      end
      // Let the new format cross to the bit clock side
      i_srr_host_model.pulse(3);
      i_srr_host_model.send_frame(bits);
      repeat (20) @(posedge clock);
    end
    check("pending", 34'h0, 34'(exp_q.size()));
    test_done();
  end
endmodule
`default_nettype wire
